/* File: rtl/pwpc_top.sv */
// three access controllers behind one register port
`include "pwpc_regs.svh"
`default_nettype none
module pwpc_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [2:0] REG_SEL,
  input wire logic REG_WRITE,
  input wire pwpc_pkg::pwpc_addr_t REG_ADDR,
  input wire pwpc_pkg::pwpc_word_t REG_WDATA,
  output pwpc_pkg::pwpc_word_t REG_RDATA,
  input wire pwpc_pkg::pwpc_word_t PROT_SET0,
  input wire pwpc_pkg::pwpc_word_t PROT_SET1,
  input wire pwpc_pkg::pwpc_word_t PROT_SET2,
  input wire pwpc_pkg::pwpc_word_t WR_SEL0,
  input wire pwpc_pkg::pwpc_word_t WR_SEL1,
  input wire pwpc_pkg::pwpc_word_t WR_SEL2,
  input wire logic WR_DBG,
  output logic WR_BLOCK0,
  output logic WR_BLOCK1,
  output logic WR_BLOCK2,
  output pwpc_pkg::pwpc_word_t PROT0,
  output pwpc_pkg::pwpc_word_t PROT1,
  output pwpc_pkg::pwpc_word_t PROT2
);
  import pwpc_pkg::*;

  logic hit;
  logic [2:0] clr_wr;
  pwpc_word_t rdata_d;
  pwpc_word_t rdata_q;

  // decode: only the clear register offset is mapped, other offsets read zero
  always_comb begin
    hit = (REG_ADDR == `PWPC_CLR_OFS);
    clr_wr = (REG_WRITE && hit) ? REG_SEL : 3'h0;
  end

  // one controller per bridge, each with its own field map
  pwpc_ctrl #(.MASK(`PWPC_C0_MASK), .RESET_VAL(`PWPC_C0_RESET)) u_ctrl0 (
    .clk(CLK),
    .rst_n(RST_N),
    .clr_wr(clr_wr[PWPC_CTRL_A]),
    .clr_data(REG_WDATA),
    .set_flags(PROT_SET0),
    .wr_sel(WR_SEL0),
    .wr_dbg(WR_DBG),
    .wr_block(WR_BLOCK0),
    .flags_q(PROT0)
  );

  pwpc_ctrl #(.MASK(`PWPC_C1_MASK), .RESET_VAL(`PWPC_C1_RESET)) u_ctrl1 (
    .clk(CLK),
    .rst_n(RST_N),
    .clr_wr(clr_wr[PWPC_CTRL_B]),
    .clr_data(REG_WDATA),
    .set_flags(PROT_SET1),
    .wr_sel(WR_SEL1),
    .wr_dbg(WR_DBG),
    .wr_block(WR_BLOCK1),
    .flags_q(PROT1)
  );

  pwpc_ctrl #(.MASK(`PWPC_C2_MASK), .RESET_VAL(`PWPC_C2_RESET)) u_ctrl2 (
    .clk(CLK),
    .rst_n(RST_N),
    .clr_wr(clr_wr[PWPC_CTRL_C]),
    .clr_data(REG_WDATA),
    .set_flags(PROT_SET2),
    .wr_sel(WR_SEL2),
    .wr_dbg(WR_DBG),
    .wr_block(WR_BLOCK2),
    .flags_q(PROT2)
  );

  // read returns live flags; if several selects are high their flags are or-ed
  always_comb begin
    rdata_d = '0;
    if (!REG_WRITE && hit) begin
      if (REG_SEL[PWPC_CTRL_A]) rdata_d = rdata_d | PROT0;
      if (REG_SEL[PWPC_CTRL_B]) rdata_d = rdata_d | PROT1;
      if (REG_SEL[PWPC_CTRL_C]) rdata_d = rdata_d | PROT2;
    end
  end

  // read word is registered so the bus sees a clean value for one whole cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA = rdata_q;

  // low only up to the first edge after reset; marks where the reset words must still stand
  logic rst_seen_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_seen_q <= 1'b0;
    end else begin
      rst_seen_q <= 1'b1;
    end
  end

  AST_READ_B: assert property (@(posedge CLK) disable iff (!RST_N)
      REG_SEL == 3'h2 && !REG_WRITE && hit |=> REG_RDATA == $past(PROT1))
    else $error("read data does not show flags");
  AST_UNMAPPED: assert property (@(posedge CLK) disable iff (!RST_N)
      !hit |=> REG_RDATA == '0)
    else $error("unmapped offset read nonzero");
  AST_DEBUG_RESET: assert property (@(posedge CLK) disable iff (!RST_N)
      !rst_seen_q |-> PROT1 == `PWPC_C1_RESET && PROT0 == '0 && PROT2 == '0)
    else $error("wrong reset value");
  AST_TRACE_MAP: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_wr[PWPC_CTRL_B] && REG_WDATA[`PWPC_C1_TRACE_BIT] && !PROT_SET1[`PWPC_C1_TRACE_BIT]
      |=> !PROT1[`PWPC_C1_TRACE_BIT])
    else $error("trace bit not cleared");
  AST_TIMER_MAP: assert property (@(posedge CLK) disable iff (!RST_N)
      PROT_SET2[`PWPC_C2_TIMER_HI:`PWPC_C2_TIMER_LO] == 8'hff
      |=> PROT2[`PWPC_C2_TIMER_HI:`PWPC_C2_TIMER_LO] == 8'hff)
    else $error("timer bits not held");
  AST_EVENT_MAP: assert property (@(posedge CLK) disable iff (!RST_N)
      PROT_SET2[`PWPC_C2_EVENT_BIT] |=> PROT2[`PWPC_C2_EVENT_BIT])
    else $error("event router bit missing");
  AST_POWER_MAP: assert property (@(posedge CLK) disable iff (!RST_N)
      PROT_SET0[`PWPC_C0_POWER_BIT] |=> PROT0[`PWPC_C0_POWER_BIT])
    else $error("power bit missing");

  // read request of one controller; its word shows on the bus one cycle after the request edge
  sequence s_rd_a;
    REG_SEL == 3'h1 && !REG_WRITE && hit;
  endsequence
  sequence s_rd_b;
    REG_SEL == 3'h2 && !REG_WRITE && hit;
  endsequence
  sequence s_rd_c;
    REG_SEL == 3'h4 && !REG_WRITE && hit;
  endsequence

  // read path: data only after a read, zero otherwise, so a stale word never lingers on the bus
  AST_READ_A: assert property (@(posedge CLK) disable iff (!RST_N)
      s_rd_a |=> REG_RDATA == $past(PROT0))
    else $error("read data does not show first flags");
  AST_READ_C: assert property (@(posedge CLK) disable iff (!RST_N)
      s_rd_c |=> REG_RDATA == $past(PROT2))
    else $error("read data does not show third flags");
  AST_READ_KEEPS: assert property (@(posedge CLK) disable iff (!RST_N)
      s_rd_b |=> (PROT1 & ~$past(PROT_SET1)) == ($past(PROT1) & ~$past(PROT_SET1)))
    else $error("read changed the flags");
  AST_RDATA_IDLE: assert property (@(posedge CLK) disable iff (!RST_N)
      REG_SEL == 3'h0 |=> REG_RDATA == '0)
    else $error("read data without a request");
  AST_RDATA_WRITE: assert property (@(posedge CLK) disable iff (!RST_N)
      REG_WRITE |=> REG_RDATA == '0)
    else $error("read data after a write");
  AST_RDATA_MAP: assert property (@(posedge CLK) disable iff (!RST_N)
      (REG_RDATA & ~(`PWPC_C0_MASK | `PWPC_C1_MASK | `PWPC_C2_MASK)) == '0)
    else $error("read data outside every map");

  // second controller fields, one check per peripheral
  AST_PORT_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_wr[PWPC_CTRL_B] && REG_WDATA[`PWPC_C1_PORT_BIT] && !PROT_SET1[`PWPC_C1_PORT_BIT]
      |=> !PROT1[`PWPC_C1_PORT_BIT])
    else $error("port unit bit not cleared");
  AST_FLASH_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_wr[PWPC_CTRL_B] && REG_WDATA[`PWPC_C1_FLASH_BIT] && !PROT_SET1[`PWPC_C1_FLASH_BIT]
      |=> !PROT1[`PWPC_C1_FLASH_BIT])
    else $error("flash bit not cleared");
  AST_DEBUG_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_wr[PWPC_CTRL_B] && REG_WDATA[`PWPC_C1_DEBUG_BIT] && !PROT_SET1[`PWPC_C1_DEBUG_BIT]
      |=> !PROT1[`PWPC_C1_DEBUG_BIT])
    else $error("debug unit bit not cleared");
  AST_TRACE_SET: assert property (@(posedge CLK) disable iff (!RST_N)
      PROT_SET1[`PWPC_C1_TRACE_BIT] |=> PROT1[`PWPC_C1_TRACE_BIT])
    else $error("trace bit missing");

  // third controller fields; the wide groups are checked as whole slices
  AST_ADC_SET: assert property (@(posedge CLK) disable iff (!RST_N)
      PROT_SET2[`PWPC_C2_ADC_BIT] |=> PROT2[`PWPC_C2_ADC_BIT])
    else $error("converter bit missing");
  AST_ADC_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_wr[PWPC_CTRL_C] && REG_WDATA[`PWPC_C2_ADC_BIT] && !PROT_SET2[`PWPC_C2_ADC_BIT]
      |=> !PROT2[`PWPC_C2_ADC_BIT])
    else $error("converter bit not cleared");
  AST_TIMER_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_wr[PWPC_CTRL_C] && REG_WDATA[`PWPC_C2_TIMER_HI:`PWPC_C2_TIMER_LO] == 8'hff
      && PROT_SET2[`PWPC_C2_TIMER_HI:`PWPC_C2_TIMER_LO] == 8'h00
      |=> PROT2[`PWPC_C2_TIMER_HI:`PWPC_C2_TIMER_LO] == 8'h00)
    else $error("timer bits not cleared");
  AST_SERIAL_SET: assert property (@(posedge CLK) disable iff (!RST_N)
      PROT_SET2[`PWPC_C2_SERIAL_HI:`PWPC_C2_SERIAL_LO] == 6'h3f
      |=> PROT2[`PWPC_C2_SERIAL_HI:`PWPC_C2_SERIAL_LO] == 6'h3f)
    else $error("serial bits not held");
  AST_SERIAL_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_wr[PWPC_CTRL_C] && REG_WDATA[`PWPC_C2_SERIAL_HI:`PWPC_C2_SERIAL_LO] == 6'h3f
      && PROT_SET2[`PWPC_C2_SERIAL_HI:`PWPC_C2_SERIAL_LO] == 6'h00
      |=> PROT2[`PWPC_C2_SERIAL_HI:`PWPC_C2_SERIAL_LO] == 6'h00)
    else $error("serial bits not cleared");
  AST_EVENT_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_wr[PWPC_CTRL_C] && REG_WDATA[`PWPC_C2_EVENT_BIT] && !PROT_SET2[`PWPC_C2_EVENT_BIT]
      |=> !PROT2[`PWPC_C2_EVENT_BIT])
    else $error("event router bit not cleared");

  // first controller fields
  AST_FIRST_SET: assert property (@(posedge CLK) disable iff (!RST_N)
      PROT_SET0[`PWPC_C0_EXT_INT_BIT:`PWPC_C0_POWER_BIT] == 6'h3f
      |=> PROT0[`PWPC_C0_EXT_INT_BIT:`PWPC_C0_POWER_BIT] == 6'h3f)
    else $error("first controller bits not held");
  AST_EXT_INT_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_wr[PWPC_CTRL_A] && REG_WDATA[`PWPC_C0_EXT_INT_BIT] && !PROT_SET0[`PWPC_C0_EXT_INT_BIT]
      |=> !PROT0[`PWPC_C0_EXT_INT_BIT])
    else $error("interrupt unit bit not cleared");
  AST_POWER_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_wr[PWPC_CTRL_A] && REG_WDATA[`PWPC_C0_POWER_BIT] && !PROT_SET0[`PWPC_C0_POWER_BIT]
      |=> !PROT0[`PWPC_C0_POWER_BIT])
    else $error("power bit not cleared");

  // bridges stay apart, and the debugger passes on every one of them
  AST_BRIDGE_APART: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_wr == 3'h2 && PROT_SET0 == '0 && PROT_SET2 == '0
      |=> PROT0 == $past(PROT0) && PROT2 == $past(PROT2))
    else $error("clear on one bridge touched another");
  AST_DBG_ALL: assert property (@(posedge CLK) disable iff (!RST_N)
      WR_DBG |-> !WR_BLOCK0 && !WR_BLOCK1 && !WR_BLOCK2)
    else $error("debugger write blocked on a bridge");
endmodule
`default_nettype wire

/* File: rtl/pwpc_regs.svh */
// register offsets, field positions and reset values of the write-protect clear block
`ifndef PWPC_REGS_SVH
`define PWPC_REGS_SVH

`define PWPC_CLR_OFS 8'h00
`define PWPC_NUM_CTRL 3
// first controller fields
`define PWPC_C0_EXT_INT_BIT 6
`define PWPC_C0_RTC_BIT 5
`define PWPC_C0_WDOG_BIT 4
`define PWPC_C0_GEN_CLK_BIT 3
`define PWPC_C0_SYS_CTL_BIT 2
`define PWPC_C0_POWER_BIT 1
`define PWPC_C0_MASK 32'h0000007e
`define PWPC_C0_RESET 32'h00000000
// second controller fields
`define PWPC_C1_TRACE_BIT 6
`define PWPC_C1_PORT_BIT 3
`define PWPC_C1_FLASH_BIT 2
`define PWPC_C1_DEBUG_BIT 1
`define PWPC_C1_MASK 32'h0000004e
`define PWPC_C1_RESET 32'h00000002
// third controller fields
`define PWPC_C2_ADC_BIT 16
`define PWPC_C2_TIMER_HI 15
`define PWPC_C2_TIMER_LO 8
`define PWPC_C2_SERIAL_HI 7
`define PWPC_C2_SERIAL_LO 2
`define PWPC_C2_EVENT_BIT 1
`define PWPC_C2_MASK 32'h0001fffe
`define PWPC_C2_RESET 32'h00000000

`endif

/* File: rtl/pwpc_pkg.sv */
// types shared by the write-protect clear block
`default_nettype none
package pwpc_pkg;
  typedef logic [31:0] pwpc_word_t;
  typedef logic [7:0] pwpc_addr_t;
  typedef enum {PWPC_CTRL_A, PWPC_CTRL_B, PWPC_CTRL_C} pwpc_ctrl_e;
endpackage
`default_nettype wire

/* File: rtl/pwpc_ctrl.sv */
// one access controller: protection flags of one bridge and its write gate
`include "pwpc_regs.svh"
`default_nettype none
module pwpc_ctrl #(
  parameter pwpc_pkg::pwpc_word_t MASK = 32'h00000000,
  parameter pwpc_pkg::pwpc_word_t RESET_VAL = 32'h00000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr_wr,
  input wire pwpc_pkg::pwpc_word_t clr_data,
  input wire pwpc_pkg::pwpc_word_t set_flags,
  input wire pwpc_pkg::pwpc_word_t wr_sel,
  input wire logic wr_dbg,
  output logic wr_block,
  output pwpc_pkg::pwpc_word_t flags_q
);
  import pwpc_pkg::*;

  pwpc_word_t flags_d;
  pwpc_word_t clr_bits;

  // ones clear, zeros keep; a set in the same cycle wins over the clear
  always_comb begin
    clr_bits = clr_wr ? clr_data : '0;
    flags_d = ((flags_q & ~clr_bits) | set_flags) & MASK;
  end

  // flag register; reset value comes from the parameter so each bridge keeps its own start state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= RESET_VAL;
    end else begin
      flags_q <= flags_d;
    end
  end

  // only writes to this bridge's own peripherals are gated; debugger writes always pass
  always_comb begin
    wr_block = (|(wr_sel & flags_q)) && !wr_dbg;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_CLEAR_ONE: assert property (clr_wr |=> (flags_q & $past(clr_data) & ~$past(set_flags)) == '0)
    else $error("written one did not clear flag");
  AST_ZERO_KEEPS: assert property (clr_wr && set_flags == '0
      |=> (flags_q & ~$past(clr_data)) == ($past(flags_q) & ~$past(clr_data)))
    else $error("written zero changed a flag");
  AST_SET_WINS: assert property (|set_flags |=> (flags_q & $past(set_flags) & MASK) == ($past(set_flags) & MASK))
    else $error("set lost against clear");
  AST_NO_STRAY: assert property ((flags_q & ~MASK) == '0)
    else $error("flag outside controller map");
  AST_BLOCK_WR: assert property ((|(wr_sel & flags_q)) && !wr_dbg |-> wr_block)
    else $error("protected write not blocked");
  AST_DBG_PASS: assert property (wr_dbg |-> !wr_block)
    else $error("debugger write blocked");
endmodule
`default_nettype wire

/* File: testbench/pwpc_bench.sv */
// self-checking bench for the write-protect clear block
`default_nettype none
module pwpc_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, reg_write, wr_dbg;
  logic [2:0] reg_sel;
  pwpc_pkg::pwpc_addr_t reg_addr;
  pwpc_pkg::pwpc_word_t reg_wdata, rdata, d;
  pwpc_pkg::pwpc_word_t pset [3];
  pwpc_pkg::pwpc_word_t wsel [3];
  pwpc_pkg::pwpc_word_t prot [3];
  logic blk [3];
  int mismatches, check_count;
  // mapped bits of each controller, worked out from the bit maps
  pwpc_pkg::pwpc_word_t masks [3] = '{32'h0000007e, 32'h0000004e, 32'h0001fffe};

  pwpc_top u_pwpc_top (.CLK(clk), .RST_N(rst_n), .REG_SEL(reg_sel), .REG_WRITE(reg_write),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .PROT_SET0(pset[0]),
    .PROT_SET1(pset[1]), .PROT_SET2(pset[2]), .WR_SEL0(wsel[0]), .WR_SEL1(wsel[1]),
    .WR_SEL2(wsel[2]), .WR_DBG(wr_dbg), .WR_BLOCK0(blk[0]), .WR_BLOCK1(blk[1]),
    .WR_BLOCK2(blk[2]), .PROT0(prot[0]), .PROT1(prot[1]), .PROT2(prot[2]));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one register access: request held for one edge, answer sampled just after that same edge
  task automatic reg_acc(input int c, input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    reg_sel <= 3'h1 << c;
    reg_write <= wr;
    reg_addr <= a;
    reg_wdata <= wd;
    @(posedge clk);
    reg_sel <= 3'h0;
    reg_write <= 1'b0;
    #1;
    d = rdata;
  endtask

  // pulse every set strobe so all mapped flags come up
  task automatic set_all();
    @(posedge clk);
    for (int c = 0; c < 3; c++) pset[c] <= 32'hffffffff;
    @(posedge clk);
    for (int c = 0; c < 3; c++) pset[c] <= 32'h00000000;
    #1;
  endtask

  task automatic t_reset();
    chk("prot0", prot[0], 32'h00000000);
    chk("prot1", prot[1], 32'h00000002);
    chk("prot2", prot[2], 32'h00000000);
    reg_acc(1, 1'b0, 8'h00, 32'h0);
    chk("read1", d, 32'h00000002);
    @(posedge clk);
    #1;
    chk("rdidle", rdata, 32'h00000000);
  endtask

  // zero writes and unmapped offsets must leave every flag alone
  task automatic t_map_zero();
    set_all();
    for (int c = 0; c < 3; c++) begin
      chk("map", prot[c], masks[c]);
      reg_acc(c, 1'b0, 8'h00, 32'h0);
      chk("read", d, masks[c]);
      reg_acc(c, 1'b1, 8'h00, 32'h0);
      chk("zero", prot[c], masks[c]);
      reg_acc(c, 1'b1, 8'h04, 32'hffffffff);
      chk("badofs", prot[c], masks[c]);
      reg_acc(c, 1'b0, 8'h04, 32'h0);
      chk("badrd", d, 32'h00000000);
    end
  endtask

  // a one in each position clears just that flag, one write at a time with an idle edge between
  task automatic t_walk();
    logic [31:0] e;
    for (int c = 0; c < 3; c++) begin
      e = masks[c];
      for (int b = 0; b < 32; b++) begin
        reg_acc(c, 1'b1, 8'h00, 32'h1 << b);
        e &= ~(32'h1 << b);
        chk("walk", prot[c], e);
      end
    end
  endtask

  // write gate: blocked while protected, debugger bypasses, bridges stay apart
  task automatic t_gate();
    set_all();
    for (int c = 0; c < 3; c++) begin
      @(posedge clk);
      wsel[c] <= 32'h00000002;
      wr_dbg <= 1'b0;
      #1;
      chk("block", {31'h0, blk[c]}, 32'h1);
      @(posedge clk);
      wr_dbg <= 1'b1;
      #1;
      chk("dbg", {31'h0, blk[c]}, 32'h0);
    end
    @(posedge clk);
    wr_dbg <= 1'b0;
    reg_acc(1, 1'b1, 8'h00, 32'hffffffff);
    chk("open1", {31'h0, blk[1]}, 32'h0);
    chk("keep0", {31'h0, blk[0]}, 32'h1);
    chk("keep2", {31'h0, blk[2]}, 32'h1);
  endtask

  // a set strobe in the same cycle as a clear write wins
  task automatic t_race();
    @(posedge clk);
    reg_sel <= 3'h4;
    reg_write <= 1'b1;
    reg_addr <= 8'h00;
    reg_wdata <= 32'hffffffff;
    pset[2] <= 32'h00010000;
    @(posedge clk);
    reg_sel <= 3'h0;
    reg_write <= 1'b0;
    pset[2] <= 32'h00000000;
    #1;
    chk("race", prot[2], 32'h00010000);
  endtask

  // reset in mid-run brings every controller back to its reset word
  task automatic t_rerst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("rst0", prot[0], 32'h00000000);
    chk("rst1", prot[1], 32'h00000002);
    chk("rst2", prot[2], 32'h00000000);
    chk("rstblk1", {31'h0, blk[1]}, 32'h1);
    chk("rstblk0", {31'h0, blk[0]}, 32'h0);
    reg_acc(1, 1'b1, 8'h00, 32'h00000002);
    chk("rstclr", prot[1], 32'h00000000);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    reg_sel = 3'h0;
    reg_write = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    wr_dbg = 1'b0;
    for (int c = 0; c < 3; c++) begin
      pset[c] = 32'h0;
      wsel[c] = 32'h0;
    end
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_map_zero();
    t_walk();
    t_gate();
    t_race();
    t_rerst();
    stop_test();
  end
endmodule
`default_nettype wire
